// >>> design/itu_params.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          interrupt and time-base unit.
// Assumes: 32-bit APB, one aligned word per register.
// Notes:   Definitions only.
`ifndef ITU_PARAMS_SVH
`define ITU_PARAMS_SVH

// ==========================================================================
// Register byte addresses
`define ITU_PRE0_OFS      12'h000
`define ITU_PRE1_OFS      12'h004
`define ITU_TBK0_OFS      12'h008
`define ITU_TBK1_OFS      12'h00c
`define ITU_IEN_OFS       12'h010
`define ITU_IFLAG_OFS     12'h014
`define ITU_CORE_OFS      12'h018

// ==========================================================================
// Field positions
`define ITU_TB_EN_BIT     7
`define ITU_GIE_BIT       7
`define ITU_SRC_CNT       5
`define ITU_SRC_TB0       0
`define ITU_SRC_TB1       1
`define ITU_SRC_SER       2
`define ITU_SRC_NVM       3
`define ITU_SRC_LOV       4

// ==========================================================================
// Reset value, base exponent, widths and stack depth
`define ITU_REG_RST       8'h00
`define ITU_TB_BASE_EXP   8
`define ITU_DIV_W         16
`define ITU_QUARTER_W     2
`define ITU_SUB_SYNC_W    2
`define ITU_PC_W          13
`define ITU_STACK_DEPTH   16
`define ITU_SP_W          5

`endif

// >>> design/itu_pkg.sv
// Purpose: Types for the interrupt and time-base unit.
// Assumes: Constants live in itu_params.svh.
// Notes:   Nothing here holds a number of its own beyond widths and the state encodings.
package itu_pkg;

  // ========================================================================
  // Core-side state
  typedef enum logic [2:0] {
    ITU_RUN   = 3'b001,
    ITU_ENTRY = 3'b010,
    ITU_SLEEP = 3'b100
  } itu_state_t;

  // Core handshake from the processor
  typedef struct packed {
    logic        ack;        // Core accepts vector this cycle
    logic [12:0] pc;         // Return address to push
    logic        ret;        // Plain return
    logic        iret;       // Return and re-enable
    logic        halt;       // Enter sleep/idle
  } itu_core_req_t;

  typedef struct packed {
    logic [2:0]  vec_id;     // Source number taken
    logic        irq;        // Request pending for the core
    logic        wake;       // Wake from sleep/idle
  } itu_core_rsp_t;

endpackage : itu_pkg

// >>> design/itu_top.sv
// Purpose: Interrupt request, vectoring and two time-base generators.
// Assumes: Peripheral events are one-cycle pulses synchronous to the clock;
//          the subsidiary clock arrives as a slow level to be sampled.
// Notes:   Registers reached over APB; only the PC is stacked.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "itu_params.svh"

// Overview of operation
// - Time base 0 prescaler source: 00 sysclk, 01 sysclk/4, 1x subclock
// - Time base 1 prescaler source chosen the same way by its own field
// - Time base 0 runs only while its control bit 7 is set
// - Time base 0 period is 2^(8+code) prescaler clocks
// - Time base 1 runs only while its control bit 7 is set
// - Time base 1 period is 2^(8+code) prescaler clocks
// - Each time base sets its own flag on divider overflow
// - Serial flag set on byte done, address match or bus time-out
// - Serial vector needs global enable, serial enable, stack not full
// - Taking serial interrupt clears its flag and global enable
// - Memory flag set when nonvolatile erase or write ends
// - Memory vector needs global enable, its enable, stack not full
// - Taking memory interrupt clears its flag and global enable
// - Low-voltage flag set when the detector reports low supply
// - Low-voltage vector needs both enables and stack not full
// - Taking low-voltage interrupt clears its flag and global enable
// - Any flag rising wakes from sleep or idle regardless of enables
// - A set flag stays set until serviced or cleared by software
// - Interrupt entry pushes only the program counter
// - Interrupt return pops and sets global enable
// - Plain return pops and leaves global enable unchanged
module itu_top (
  input  wire logic                  CORE_CLK_IN,
  input  wire logic                  RST_B_IN,
  input  wire logic                  PSEL_IN,
  input  wire logic                  PENABLE_IN,
  input  wire logic                  PWRITE_IN,
  input  wire logic [11:0]           PADDR_IN,
  input  wire logic [31:0]           PWDATA_IN,
  output logic      [31:0]           PRDATA_OUT,
  output logic                       PREADY_OUT,
  output logic                       PSLVERR_OUT,
  input  wire logic                  SUB_CLK_IN,
  input  wire logic                  SER_EVENT_IN,
  input  wire logic                  NVM_DONE_IN,
  input  wire logic                  LOW_VOLTAGE_IN,
  input  wire itu_pkg::itu_core_req_t CORE_REQ_IN,
  output itu_pkg::itu_core_rsp_t     CORE_RSP_OUT,
  output logic [`ITU_PC_W-1:0]       RET_PC_OUT,
  output logic                       STACK_FULL_OUT
);

  // ========================================================================
  // Register state
  logic [1:0]                 psc_sel_reg [2];
  logic [7:0]                 tb_ctrl_reg [2];
  logic [`ITU_SRC_CNT-1:0]    ien_reg;
  logic                       gie_reg;
  logic [`ITU_SRC_CNT-1:0]    flag_reg;
  logic [`ITU_SRC_CNT-1:0]    flag_next;
  logic [`ITU_SRC_CNT-1:0]    tb_ovf;
  logic [`ITU_SRC_CNT-1:0]    hw_set;
  logic [`ITU_SRC_CNT-1:0]    take_clr;
  logic [`ITU_SRC_CNT-1:0]    pend;
  logic [`ITU_SRC_CNT-1:0]    sel_onehot;
  logic [2:0]                 sel_id;
  logic                       any_pend;
  logic [`ITU_PC_W-1:0]       stack_mem [`ITU_STACK_DEPTH];
  logic [`ITU_SP_W-1:0]       sp_reg;
  logic                       stack_full;
  logic                       take;
  logic                       wr_en;
  logic                       rd_en;
  logic                       addr_ok;
  logic [`ITU_QUARTER_W-1:0]  quarter_reg;
  logic                       sub_s1_reg;
  logic                       sub_s2_reg;
  logic                       sub_s3_reg;
  logic                       sub_tick;
  logic                       rise_any;
  itu_pkg::itu_state_t        state_reg;
  itu_pkg::itu_state_t        state_next;

  // ========================================================================
  // APB decode; zero-wait slave, unmapped reads zero with error
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && addr_ok;
  assign rd_en = PSEL_IN && PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;

  always_comb
  begin
    unique case (PADDR_IN)
      `ITU_PRE0_OFS, `ITU_PRE1_OFS, `ITU_TBK0_OFS, `ITU_TBK1_OFS,
      `ITU_IEN_OFS, `ITU_IFLAG_OFS, `ITU_CORE_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Error flagged only in the access phase
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

  // Read data registered so the data output comes from flip-flops
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      PRDATA_OUT <= 32'h0;
    else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
    begin
      unique case (PADDR_IN)
        `ITU_PRE0_OFS:  PRDATA_OUT <= {30'h0, psc_sel_reg[0]};
        `ITU_PRE1_OFS:  PRDATA_OUT <= {30'h0, psc_sel_reg[1]};
        `ITU_TBK0_OFS:  PRDATA_OUT <= {24'h0, tb_ctrl_reg[0]};
        `ITU_TBK1_OFS:  PRDATA_OUT <= {24'h0, tb_ctrl_reg[1]};
        `ITU_IEN_OFS:   PRDATA_OUT <= {24'h0, gie_reg, 2'h0, ien_reg};
        `ITU_IFLAG_OFS: PRDATA_OUT <= {27'h0, flag_reg};
        `ITU_CORE_OFS:  PRDATA_OUT <= {26'h0, stack_full, sp_reg};
        default:        PRDATA_OUT <= 32'h0;
      endcase
    end
  end

  // ========================================================================
  // Configuration registers; reserved bits are not stored
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      psc_sel_reg[0] <= 2'h0;
      psc_sel_reg[1] <= 2'h0;
      tb_ctrl_reg[0] <= `ITU_REG_RST;
      tb_ctrl_reg[1] <= `ITU_REG_RST;
      ien_reg        <= 5'h0;
    end
    else if (wr_en)
    begin
      unique case (PADDR_IN)
        `ITU_PRE0_OFS: psc_sel_reg[0] <= PWDATA_IN[1:0];
        `ITU_PRE1_OFS: psc_sel_reg[1] <= PWDATA_IN[1:0];
        `ITU_TBK0_OFS: tb_ctrl_reg[0] <= {PWDATA_IN[7], 4'h0,
                                          PWDATA_IN[2:0]};
        `ITU_TBK1_OFS: tb_ctrl_reg[1] <= {PWDATA_IN[7], 4'h0,
                                          PWDATA_IN[2:0]};
        `ITU_IEN_OFS:  ien_reg <= PWDATA_IN[4:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Prescaler ticks: quarter divider and subclock edge
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      quarter_reg <= 2'h0;
    else
      quarter_reg <= quarter_reg + 2'h1;
  end

  // Subclock sampled by three flops; edge taken from stage two onward
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      sub_s1_reg <= 1'b0;
      sub_s2_reg <= 1'b0;
      sub_s3_reg <= 1'b0;
    end
    else
    begin
      sub_s1_reg <= SUB_CLK_IN;
      sub_s2_reg <= sub_s1_reg;
      sub_s3_reg <= sub_s2_reg;
    end
  end
  assign sub_tick = sub_s2_reg && !sub_s3_reg;

  // ========================================================================
  // Two time bases, one per generate entry
  for (genvar t = 0; t < 2; t++)
  begin : g_tb
    logic [`ITU_DIV_W-1:0] div_reg;
    logic                  tick;
    logic [3:0]            exp;

    // Source select; subclock used for any 1x code
    always_comb
    begin
      unique casez (psc_sel_reg[t])
        2'b00:   tick = 1'b1;
        2'b01:   tick = (quarter_reg == 2'h3);
        default: tick = sub_tick;
      endcase
    end

    assign exp = 4'(`ITU_TB_BASE_EXP) + {1'b0, tb_ctrl_reg[t][2:0]};

    // Divider cleared while off so it restarts a full period
    always_ff @(posedge CORE_CLK_IN)
    begin
      if (!RST_B_IN || !tb_ctrl_reg[t][`ITU_TB_EN_BIT])
        div_reg <= '0;
      else if (tick)
        div_reg <= tb_ovf[t] ? '0 : div_reg + 16'h1;
    end

    // Overflow when count reaches 2^exp - 1 on a tick
    assign tb_ovf[t] = tb_ctrl_reg[t][`ITU_TB_EN_BIT] && tick &&
                       (div_reg == 16'((32'h1 << exp) - 1));

    a_tb_off_zero: assert property (@(posedge CORE_CLK_IN)
      disable iff (!RST_B_IN)
      !tb_ctrl_reg[t][`ITU_TB_EN_BIT] |=> div_reg == '0)
      else $error("divider not held while disabled");
    a_tb_period: assert property (@(posedge CORE_CLK_IN)
      disable iff (!RST_B_IN)
      (tb_ovf[t] && psc_sel_reg[t] == 2'b00 && tb_ctrl_reg[t][2:0] == 3'h0
       && $stable(tb_ctrl_reg[t]))
      |=> (!tb_ovf[t])[*8])
      else $error("time base overflow too early");
  end
  assign tb_ovf[4:2] = 3'h0;

  // ========================================================================
  // Request flags: set wins over any clear
  assign hw_set = {LOW_VOLTAGE_IN, NVM_DONE_IN, SER_EVENT_IN,
                   tb_ovf[1:0]};

  always_comb
  begin
    flag_next = flag_reg & ~take_clr;
    if (wr_en && PADDR_IN == `ITU_IFLAG_OFS)
      flag_next = PWDATA_IN[4:0];                 // Software set or clear
    flag_next = flag_next | hw_set;
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      flag_reg <= 5'h0;
    else
      flag_reg <= flag_next;
  end

  // ========================================================================
  // Fixed priority: lowest source number wins
  assign pend     = flag_reg & ien_reg;
  assign any_pend = gie_reg && !stack_full && (pend != 5'h0);
  assign sel_onehot = pend & (~pend + 5'h1);

  always_comb
  begin
    sel_id = 3'h0;
    for (int i = `ITU_SRC_CNT - 1; i >= 0; i--)
      if (pend[i])
        sel_id = 3'(i);
  end

  assign take     = any_pend && CORE_REQ_IN.ack && state_reg == itu_pkg::ITU_RUN;
  assign take_clr = take ? sel_onehot : 5'h0;

  // ========================================================================
  // Global enable; entry clears it, interrupt return sets it
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      gie_reg <= 1'b0;
    else if (take)
      gie_reg <= 1'b0;
    else if (CORE_REQ_IN.iret)
      gie_reg <= 1'b1;
    else if (wr_en && PADDR_IN == `ITU_IEN_OFS)
      gie_reg <= PWDATA_IN[`ITU_GIE_BIT];        // Plain return skips this
  end

  // ========================================================================
  // Return stack holds the PC alone; no other state saved
  assign stack_full = (sp_reg == 5'(`ITU_STACK_DEPTH));

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      sp_reg <= '0;
    else if (take)
      sp_reg <= sp_reg + 5'h1;
    else if ((CORE_REQ_IN.ret || CORE_REQ_IN.iret) && sp_reg != '0)
      sp_reg <= sp_reg - 5'h1;
  end

  // Memory needs no reset; only entries below the pointer are read
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (take)
      stack_mem[sp_reg[3:0]] <= CORE_REQ_IN.pc;
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      RET_PC_OUT <= '0;
    else if ((CORE_REQ_IN.ret || CORE_REQ_IN.iret) && sp_reg != '0)
      RET_PC_OUT <= stack_mem[4'(sp_reg - 5'h1)];
  end
  assign STACK_FULL_OUT = stack_full;

  // ========================================================================
  // Sleep tracking and wake on any flag rising
  assign rise_any = |(flag_next & ~flag_reg);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      itu_pkg::ITU_RUN:
        if (take)
          state_next = itu_pkg::ITU_ENTRY;
        else if (CORE_REQ_IN.halt)
          state_next = itu_pkg::ITU_SLEEP;
      itu_pkg::ITU_ENTRY:
        state_next = itu_pkg::ITU_RUN;
      itu_pkg::ITU_SLEEP:
        if (rise_any)
          state_next = itu_pkg::ITU_RUN;
      default:
        state_next = itu_pkg::ITU_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      state_reg <= itu_pkg::ITU_RUN;
    else
      state_reg <= state_next;
  end

  // Outputs to the core
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_B_IN)
      CORE_RSP_OUT <= '0;
    else
    begin
      CORE_RSP_OUT.vec_id <= sel_id;
      CORE_RSP_OUT.irq    <= any_pend && !take;
      CORE_RSP_OUT.wake   <= state_reg == itu_pkg::ITU_SLEEP && rise_any;
    end
  end

  // ========================================================================
  // Checks
  sequence s_entry;
    take ##1 (!gie_reg && sp_reg == $past(sp_reg) + 5'h1);
  endsequence

  a_entry_clears: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    take |-> s_entry)
    else $error("entry did not clear enable or push");
  a_needs_enable: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    take |-> gie_reg && !stack_full)
    else $error("vector taken while disabled or full");
  a_iret_sets: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    (CORE_REQ_IN.iret && !take) |=> gie_reg)
    else $error("interrupt return left enable low");
  a_ret_keeps: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    (CORE_REQ_IN.ret && !CORE_REQ_IN.iret && !take && !wr_en)
    |=> $stable(gie_reg))
    else $error("plain return changed enable");
  a_flag_sticky: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    (flag_reg[2] && !take_clr[2] && !wr_en) |=> flag_reg[2])
    else $error("flag dropped without service or clear");
  a_event_sets: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    (SER_EVENT_IN || NVM_DONE_IN || LOW_VOLTAGE_IN)
    |=> flag_reg[4:2] != 3'h0)
    else $error("event did not set a flag");
  a_one_source: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    take |-> $onehot(take_clr))
    else $error("more than one flag serviced");
  a_wake_rise: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RST_B_IN)
    (state_reg == itu_pkg::ITU_SLEEP && rise_any)
    |=> CORE_RSP_OUT.wake && state_reg == itu_pkg::ITU_RUN)
    else $error("flag rise did not wake");

endmodule // itu_top

// >>> test/itu_core_model.sv
// Purpose: Core-side stand-in for the interrupt unit.
// Assumes: Returns and halt arrive as one-cycle pulses from the bench.
// Notes:   Each accepted vector pushes a return address 0x11 above the last.
`include "itu_params.svh"
module itu_core_model (
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  input  wire itu_pkg::itu_core_rsp_t rsp_in,
  input  wire logic                   ack_en_in,
  input  wire logic [2:0]             delay_in,
  input  wire logic                   ret_in,
  input  wire logic                   iret_in,
  input  wire logic                   halt_in,
  output itu_pkg::itu_core_req_t      req_out
);
  logic [2:0]           hold_reg;
  logic                 armed_reg;
  logic [`ITU_PC_W-1:0] pc_reg;

  // ======================================================================
  // Vector accept; re-arms only once irq drops, so a stale irq is not
  // accepted twice
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      req_out   <= '0;
      hold_reg  <= 3'h0;
      armed_reg <= 1'b1;
      pc_reg    <= 13'h0100;
    end
    else
    begin
      req_out.ret  <= ret_in;
      req_out.iret <= iret_in;
      req_out.halt <= halt_in;
      req_out.ack  <= 1'b0;
      hold_reg     <= rsp_in.irq ? hold_reg + 3'h1 : 3'h0;
      if (!rsp_in.irq)
        armed_reg <= 1'b1;
      // Grouped sources absent, nothing for software to clear here
      if (ack_en_in && rsp_in.irq && armed_reg && hold_reg >= delay_in)
      begin
        req_out.ack <= 1'b1;
        req_out.pc  <= pc_reg;
        pc_reg      <= pc_reg + 13'h0011;
        armed_reg   <= 1'b0;
      end
    end
  end
endmodule // itu_core_model

// >>> test/itu_tb_top.sv
// Purpose: Self-checking bench for the interrupt and time-base unit.
// Assumes: Zero-wait APB slave; core stand-in answers vectors.
// Notes:   Subsidiary clock is a level toggled every 5 cycles.
`include "itu_params.svh"
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module itu_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
  } itu_row_t;
  localparam itu_row_t ROWS [12] = '{
    '{12'h000, 32'hffffffff, 32'h03, 1'b0}, '{12'h004, 32'hff, 32'h03, 1'b0},
    '{12'h008, 32'hff, 32'h87, 1'b0}, '{12'h00c, 32'hff, 32'h87, 1'b0},
    '{12'h008, 32'h00, 32'h00, 1'b0}, '{12'h00c, 32'h00, 32'h00, 1'b0},
    '{12'h000, 32'h00, 32'h00, 1'b0}, '{12'h004, 32'h00, 32'h00, 1'b0},
    '{12'h010, 32'hff, 32'h9f, 1'b0}, '{12'h010, 32'h00, 32'h00, 1'b0},
    '{12'h018, 32'hff, 32'h00, 1'b0}, '{12'h01c, 32'hff, 32'h00, 1'b1}};
  localparam int TB_ID [5] = '{0, 0, 1, 1, 0};
  localparam int SRC [5]   = '{0, 1, 0, 2, 3};
  localparam int CODE [5]  = '{0, 0, 1, 0, 1};
  localparam int DIV [4]   = '{1, 4, 10, 10};
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0, prdata, rd;
  logic                   pready, pslverr, err, full, w;
  logic                   sub_clk = 1'b0, ser_ev = 1'b0, nvm_ev = 1'b0;
  logic                   lv_ev = 1'b0, ack_en = 1'b0, halt_p = 1'b0;
  logic                   ret_p = 1'b0, iret_p = 1'b0;
  logic [2:0]             dly = 3'h1;
  logic [12:0]            ret_pc;
  itu_pkg::itu_core_req_t req;
  itu_pkg::itu_core_rsp_t rsp;
  int                     bad_count = 0, n_compared = 0, cyc = 0, sc = 0;
  int                     t1, t2, d1, d2;

  itu_top dut_u (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SUB_CLK_IN(sub_clk), .SER_EVENT_IN(ser_ev),
    .NVM_DONE_IN(nvm_ev), .LOW_VOLTAGE_IN(lv_ev), .CORE_REQ_IN(req),
    .CORE_RSP_OUT(rsp), .RET_PC_OUT(ret_pc), .STACK_FULL_OUT(full));
  itu_core_model core_u (.clk_in(clk), .rst_b_in(rst_b), .rsp_in(rsp),
    .ack_en_in(ack_en), .delay_in(dly), .ret_in(ret_p), .iret_in(iret_p),
    .halt_in(halt_p), .req_out(req));

  // ======================================================================
  // Clock, cycle count and a 10-cycle subsidiary clock
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sc  <= (sc == 4) ? 0 : sc + 1;
    if (sc == 4)
      sub_clk <= ~sub_clk;
  end

  // APB transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Bounded wait on irq; returns the cycle it was seen
  task automatic wait_irq(input logic lvl, output int t);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (rsp.irq !== lvl && k < 20000);
    t = cyc;
  endtask

  // One-cycle pulse of {halt, iret, ret, lv, nvm, serial}
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    {halt_p, iret_p, ret_p, lv_ev, nvm_ev, ser_ev} <= m;
    @(posedge clk);
    {halt_p, iret_p, ret_p, lv_ev, nvm_ev, ser_ev} <= 6'h00;
    repeat (4) @(posedge clk);
  endtask

  // Wake lasts one cycle, so watch from the event edge onward
  task automatic look_wake(input logic [5:0] m);
    w = 1'b0;
    @(posedge clk);
    {halt_p, iret_p, ret_p, lv_ev, nvm_ev, ser_ev} <= m;
    @(posedge clk);
    {halt_p, iret_p, ret_p, lv_ev, nvm_ev, ser_ev} <= 6'h00;
    repeat (8)
    begin
      @(negedge clk);
      if (rsp.wake === 1'b1)
        w = 1'b1;
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ======================================================================
  // Watchdog well beyond the expected 21k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // Register table rows: write, then read back
    foreach (ROWS[i])
    begin
      apb(1'b1, ROWS[i].a, ROWS[i].w);
      `CHK(err, ROWS[i].e)
      rdchk(ROWS[i].a, ROWS[i].r);
    end
    // Periods for sources 00, 01, 10 with code 0 and 00, 11 with code 1, overflow to overflow
    foreach (SRC[i])
    begin
      apb(1'b1, 12'(4 * TB_ID[i]), 32'(SRC[i]));
      apb(1'b1, `ITU_IEN_OFS, 32'h80 | (32'h1 << TB_ID[i]));
      apb(1'b1, 12'(8 + 4 * TB_ID[i]), 32'h80 | 32'(CODE[i]));
      wait_irq(1'b1, t1);
      apb(1'b1, `ITU_IFLAG_OFS, 32'h0);
      wait_irq(1'b0, t2);
      wait_irq(1'b1, t2);
      `CHK(t2 - t1, DIV[SRC[i]] << (8 + CODE[i]))
      apb(1'b1, 12'(8 + 4 * TB_ID[i]), 32'h0);
      apb(1'b1, `ITU_IFLAG_OFS, 32'h0);
    end
    // Disable mid-count: no overflow, then a full period after re-enable
    apb(1'b1, `ITU_PRE0_OFS, 32'h0);
    apb(1'b1, `ITU_TBK0_OFS, 32'h80);
    t1 = cyc;
    wait_irq(1'b1, d1);
    apb(1'b1, `ITU_IFLAG_OFS, 32'h0);
    apb(1'b1, `ITU_TBK0_OFS, 32'h80);
    t2 = cyc;
    repeat (150) @(posedge clk);
    apb(1'b1, `ITU_TBK0_OFS, 32'h00);
    repeat (300) @(negedge clk);
    `CHK(rsp.irq, 1'b0)
    apb(1'b1, `ITU_TBK0_OFS, 32'h80);
    t2 = cyc;
    wait_irq(1'b1, d2);
    `CHK(d2 - t2, d1 - t1)
    apb(1'b1, `ITU_TBK0_OFS, 32'h0);
    apb(1'b1, `ITU_IEN_OFS, 32'h0);
    apb(1'b1, `ITU_IFLAG_OFS, 32'h0);
    // Three sources at once, enables off: flags stay
    pulse(6'h07);
    rdchk(`ITU_IFLAG_OFS, 32'h1c);
    ack_en <= 1'b1;
    dly    <= 3'h4;
    apb(1'b1, `ITU_IEN_OFS, 32'h9c);
    wait_irq(1'b1, t1);
    `CHK(rsp.vec_id, 3'h2)
    wait_irq(1'b0, t1);
    rdchk(`ITU_IEN_OFS, 32'h1c);
    rdchk(`ITU_IFLAG_OFS, 32'h18);
    dly <= 3'h1;
    pulse(6'h10);
    `CHK(ret_pc, 13'h0100)
    wait_irq(1'b1, t1);
    `CHK(rsp.vec_id, 3'h3)
    wait_irq(1'b0, t1);
    rdchk(`ITU_IFLAG_OFS, 32'h10);
    pulse(6'h08);
    `CHK(ret_pc, 13'h0111)
    rdchk(`ITU_IEN_OFS, 32'h1c);
    `CHK(rsp.irq, 1'b0)
    apb(1'b1, `ITU_IEN_OFS, 32'h9c);
    wait_irq(1'b1, t1);
    `CHK(rsp.vec_id, 3'h4)
    wait_irq(1'b0, t1);
    rdchk(`ITU_IFLAG_OFS, 32'h00);
    pulse(6'h10);
    `CHK(ret_pc, 13'h0122)
    // Fill the 16-entry stack, then a request must be held off
    repeat (16)
    begin
      apb(1'b1, `ITU_IFLAG_OFS, 32'h04);
      apb(1'b1, `ITU_IEN_OFS, 32'h84);
      wait_irq(1'b1, t1);
      wait_irq(1'b0, t1);
    end
    rdchk(`ITU_CORE_OFS, 32'h30);
    apb(1'b1, `ITU_IFLAG_OFS, 32'h04);
    apb(1'b1, `ITU_IEN_OFS, 32'h84);
    repeat (20) @(negedge clk);
    `CHK(rsp.irq, 1'b0)
    apb(1'b1, `ITU_IEN_OFS, 32'h0);
    apb(1'b1, `ITU_IFLAG_OFS, 32'h0);
    repeat (16) pulse(6'h08);
    `CHK(ret_pc, 13'h0133)
    `CHK(full, 1'b0)
    // Wake on a rising flag, none when the flag was preset
    pulse(6'h20);
    look_wake(6'h04);
    `CHK(w, 1'b1)
    apb(1'b1, `ITU_IFLAG_OFS, 32'h10);
    pulse(6'h20);
    look_wake(6'h04);
    `CHK(w, 1'b0)
    // Reset in mid-run clears every register
    apb(1'b1, `ITU_PRE1_OFS, 32'h3);
    apb(1'b1, `ITU_TBK1_OFS, 32'h87);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 28; a += 4)
      rdchk(12'(a), 32'h0);
    conclude();
  end
endmodule // itu_tb_top
